//--- spc_serial_ctrl.sv
// serial control register block: APB slave, status flags and interrupt requests
//
// Operation
// - control register eight bits, cleared by reset/standby
// - all control bits readable and writable anytime
// - tx empty request when enabled and empty
// - tx empty request drops with flag/enable
// - rx full request enable gates full and error requests
// - error request for overrun, framing, parity
// - rx request drops with flags or enable
// - tx off: pin is port, empty flag one
// - tx on: holding write clears empty, starts
// - rx off: pin port, rx flags kept
// - rx on: pin receives, start detected
// - address wait only async with address mode
// - address wait suppresses store, requests, flags but the addr bit
// - address char sets bit, clears wait
// - tx done request on MSB with empty buffer
// - tx done drops with flags or enable
// - clock select decodes source and pin role
module spc_serial_ctrl
  import spc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // power mode: standby, module standby or watch
  input wire logic standbyReq,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // format bits from serial_format_reg
  input wire logic syncSelect,
  input wire logic addrModeEn,
  // shifter events
  input wire logic txLoadEvt,
  input wire logic txMsbEvt,
  input wire spc_rx_evt_t rxEvt,
  // shifter and pin control
  output logic [7:0] txDataOut,
  output logic txStartStb,
  output logic txPinSel,
  output logic rxPinSel,
  output spc_clk_cfg_t clkCfg,
  // interrupt requests
  output logic txEmptyIrq,
  output logic rxFullIrq,
  output logic rxErrorIrq,
  output logic txDoneIrq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ctrlReg;
  logic txEmpty_reg;
  logic rxFull_reg;
  logic overrun_reg;
  logic framing_reg;
  logic parity_reg;
  logic txEnd_reg;
  logic addrBitRx_reg;
  logic [7:0] txHold_reg;
  logic [7:0] rxHold_reg;
  logic [7:0] flagsView;
  logic clearAll;
  logic wrDone;
  logic rdDone;
  logic wrCtrl;
  logic wrFlags;
  logic wrTx;
  logic rdRx;
  logic txOn;
  logic rxOn;
  logic addrWait;
  logic rxAccept;
  logic rxSkip;
  logic rxAddrHit;
  logic rxStore;

  assign clearAll = sys_rst | standbyReq;
  assign txOn = ctrlReg[CTRL_TX_ON];
  assign rxOn = ctrlReg[CTRL_RX_ON];
  assign flagsView = {txEmpty_reg, rxFull_reg, overrun_reg, framing_reg,
                      parity_reg, txEnd_reg, addrBitRx_reg, 1'b0};

  // ---------------------------------------------------------------
  // apb slave: one wait-free access cycle, answer prepared in setup
  // ---------------------------------------------------------------
  assign wrDone = psel & penable & pready & pwrite;
  assign rdDone = psel & penable & pready & ~pwrite;
  assign wrCtrl = wrDone & (paddr == SPC_CTRL_OFS);
  assign wrFlags = wrDone & (paddr == SPC_FLAGS_OFS);
  assign wrTx = wrDone & (paddr == SPC_TXDATA_OFS);
  assign rdRx = rdDone & (paddr == SPC_RXDATA_OFS);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      case (paddr)
        SPC_CTRL_OFS: prdata <= {24'h00_0000, ctrlReg};
        SPC_FLAGS_OFS: prdata <= {24'h00_0000, flagsView};
        SPC_TXDATA_OFS: prdata <= {24'h00_0000, txHold_reg};
        SPC_RXDATA_OFS: prdata <= {24'h00_0000, rxHold_reg};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive qualification
  // ---------------------------------------------------------------
  // address wait only counts in async mode with address mode on
  assign addrWait = ctrlReg[CTRL_ADDR_WAIT_IRQ_EN] & ~syncSelect & addrModeEn;
  assign rxAccept = rxEvt.done & rxOn;
  assign rxSkip = rxAccept & addrWait & ~rxEvt.addrBit;
  assign rxAddrHit = rxAccept & addrWait & rxEvt.addrBit;
  // an error keeps the old holding data and full flag
  assign rxStore = rxAccept & ~rxSkip & ~rxFull_reg & ~rxEvt.frameErr & ~rxEvt.parityErr;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      ctrlReg <= CTRL_RESET;
    end else begin
      if (wrCtrl) begin
        ctrlReg <= pwdata[7:0];
      end
      // hardware clear wins over a software write in the same cycle
      if (rxAddrHit) begin
        ctrlReg[CTRL_ADDR_WAIT_IRQ_EN] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit flags and holding register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      txEmpty_reg <= FLAGS_RESET[FLAG_TX_BUF_EMPTY];
      txEnd_reg <= FLAGS_RESET[FLAG_TX_END];
      txHold_reg <= TXDATA_RESET;
      txStartStb <= 1'b0;
    end else begin
      txStartStb <= wrTx & txOn;
      if (wrTx) begin
        txHold_reg <= pwdata[7:0];
      end
      if (~txOn) begin
        txEmpty_reg <= 1'b1;
      end else if (txLoadEvt) begin
        txEmpty_reg <= 1'b1;
      end else if (wrTx | (wrFlags & ~pwdata[FLAG_TX_BUF_EMPTY])) begin
        txEmpty_reg <= 1'b0;
      end
      if (txMsbEvt & txEmpty_reg) begin
        txEnd_reg <= 1'b1;
      end else if (wrTx | (wrFlags & ~pwdata[FLAG_TX_BUF_EMPTY])) begin
        txEnd_reg <= 1'b0;
      end
    end
  end

  assign txDataOut = txHold_reg;

  // ---------------------------------------------------------------
  // receive flags and holding register
  // ---------------------------------------------------------------
  // flags are only set by accepted characters, so clearing rx_on keeps them
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      rxFull_reg <= FLAGS_RESET[FLAG_RX_BUF_FULL];
      overrun_reg <= FLAGS_RESET[FLAG_OVERRUN];
      framing_reg <= FLAGS_RESET[FLAG_FRAMING];
      parity_reg <= FLAGS_RESET[FLAG_PARITY];
      addrBitRx_reg <= FLAGS_RESET[FLAG_ADDR_BIT_RX];
      rxHold_reg <= 8'h00;
    end else begin
      if (rxStore) begin
        rxHold_reg <= rxEvt.data;
      end
      if (rxStore) begin
        rxFull_reg <= 1'b1;
      end else if (rdRx | (wrFlags & ~pwdata[FLAG_RX_BUF_FULL])) begin
        rxFull_reg <= 1'b0;
      end
      if (rxAccept & ~rxSkip & rxFull_reg) begin
        overrun_reg <= 1'b1;
      end else if (wrFlags & ~pwdata[FLAG_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (rxAccept & ~rxSkip & ~rxFull_reg & rxEvt.frameErr) begin
        framing_reg <= 1'b1;
      end else if (wrFlags & ~pwdata[FLAG_FRAMING]) begin
        framing_reg <= 1'b0;
      end
      if (rxAccept & ~rxSkip & ~rxFull_reg & rxEvt.parityErr) begin
        parity_reg <= 1'b1;
      end else if (wrFlags & ~pwdata[FLAG_PARITY]) begin
        parity_reg <= 1'b0;
      end
      if (rxAccept & addrModeEn & ~syncSelect) begin
        addrBitRx_reg <= rxEvt.addrBit;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin roles and clock source
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      txPinSel <= 1'b0;
      rxPinSel <= 1'b0;
      clkCfg <= '0;
    end else begin
      txPinSel <= txOn;
      rxPinSel <= rxOn;
      case (ctrlReg[CTRL_CLK_SEL_HI:CTRL_CLK_SEL_LO])
        2'b00: clkCfg <= '{clkOutEn: syncSelect, clkIsInput: 1'b0, bitRateOut: 1'b0, reserved: 1'b0};
        2'b01: clkCfg <= '{clkOutEn: ~syncSelect, clkIsInput: 1'b0, bitRateOut: ~syncSelect,
                           reserved: syncSelect};
        2'b10: clkCfg <= '{clkOutEn: 1'b0, clkIsInput: 1'b1, bitRateOut: 1'b0, reserved: 1'b0};
        default: clkCfg <= '{clkOutEn: 1'b0, clkIsInput: 1'b0, bitRateOut: 1'b0, reserved: 1'b1};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests: levels, one register stage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      txEmptyIrq <= 1'b0;
      rxFullIrq <= 1'b0;
      rxErrorIrq <= 1'b0;
      txDoneIrq <= 1'b0;
    end else begin
      txEmptyIrq <= ctrlReg[CTRL_TX_EMPTY_IRQ_EN] & txEmpty_reg;
      rxFullIrq <= ctrlReg[CTRL_RX_FULL_IRQ_EN] & rxFull_reg;
      rxErrorIrq <= ctrlReg[CTRL_RX_FULL_IRQ_EN] & (overrun_reg | framing_reg | parity_reg);
      txDoneIrq <= ctrlReg[CTRL_TX_DONE_IRQ_EN] & txEnd_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_addrHit;
    rxAccept && addrWait && rxEvt.addrBit;
  endsequence

  sequence s_waitReleased;
    !ctrlReg[CTRL_ADDR_WAIT_IRQ_EN] && addrBitRx_reg;
  endsequence

  AST_CTRL_CLEAR: assert property (standbyReq |=> ctrlReg == CTRL_RESET)
    else $error("control register not cleared by standby");
  AST_CTRL_WRITE: assert property (wrCtrl && !rxAddrHit && !standbyReq |=> ctrlReg == $past(pwdata[7:0]))
    else $error("control write not stored");
  AST_TX_EMPTY_IRQ: assert property (ctrlReg[CTRL_TX_EMPTY_IRQ_EN] && txEmpty_reg && !standbyReq
    |=> txEmptyIrq)
    else $error("tx empty request missing");
  AST_TX_EMPTY_DROP: assert property (!txEmpty_reg |=> !txEmptyIrq)
    else $error("tx empty request not withdrawn");
  AST_RX_IRQ: assert property (rxStore && ctrlReg[CTRL_RX_FULL_IRQ_EN] && !standbyReq && !wrCtrl
    |=> ##1 rxFullIrq)
    else $error("rx full request not raised after store");
  AST_RX_ERR: assert property (!ctrlReg[CTRL_RX_FULL_IRQ_EN] |=> !rxErrorIrq && !rxFullIrq)
    else $error("rx requests active while disabled");
  AST_TX_OFF: assert property (!txOn && !standbyReq |=> txEmpty_reg && !txPinSel)
    else $error("tx empty flag not held while tx off");
  AST_TX_WRITE: assert property (wrTx && txOn && !txLoadEvt && !standbyReq
    |=> !txEmpty_reg && txStartStb)
    else $error("holding write did not start transmit");
  AST_RX_KEEP: assert property ($fell(rxOn) && !standbyReq |=> $stable({rxFull_reg, overrun_reg, framing_reg, parity_reg})
    || $past(wrFlags) || $past(rdRx))
    else $error("rx flags changed when rx turned off");
  AST_ADDR_SKIP: assert property (rxSkip && !standbyReq |=> $stable(rxFull_reg) || $past(rdRx) || $past(wrFlags))
    else $error("flags moved during address wait");
  AST_ADDR_HIT: assert property (s_addrHit and !standbyReq |=> s_waitReleased)
    else $error("address character did not release wait");
  AST_TX_DONE: assert property (txMsbEvt && txEmpty_reg && ctrlReg[CTRL_TX_DONE_IRQ_EN] && !standbyReq
    && !wrCtrl |=> ##1 txDoneIrq)
    else $error("tx done request missing");
endmodule : spc_serial_ctrl

//--- spc_pkg.sv
// package: register map, field positions and carriers for the serial control block
package spc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPC_FLAGS_OFS = 8'h04;
  localparam logic [7:0] SPC_TXDATA_OFS = 8'h08;
  localparam logic [7:0] SPC_RXDATA_OFS = 8'h0C;

  // ---------------------------------------------------------------
  // serial_ctrl_reg fields
  // ---------------------------------------------------------------
  localparam int CTRL_TX_EMPTY_IRQ_EN = 7;
  localparam int CTRL_RX_FULL_IRQ_EN = 6;
  localparam int CTRL_TX_ON = 5;
  localparam int CTRL_RX_ON = 4;
  localparam int CTRL_ADDR_WAIT_IRQ_EN = 3;
  localparam int CTRL_TX_DONE_IRQ_EN = 2;
  localparam int CTRL_CLK_SEL_HI = 1;
  localparam int CTRL_CLK_SEL_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // serial_flags_reg fields
  // ---------------------------------------------------------------
  localparam int FLAG_TX_BUF_EMPTY = 7;
  localparam int FLAG_RX_BUF_FULL = 6;
  localparam int FLAG_OVERRUN = 5;
  localparam int FLAG_FRAMING = 4;
  localparam int FLAG_PARITY = 3;
  localparam int FLAG_TX_END = 2;
  localparam int FLAG_ADDR_BIT_RX = 1;
  localparam logic [7:0] FLAGS_RESET = 8'h84;
  localparam logic [7:0] TXDATA_RESET = 8'hFF;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic addrBit;
    logic frameErr;
    logic parityErr;
    logic [7:0] data;
  } spc_rx_evt_t;

  typedef struct packed {
    logic clkOutEn;
    logic clkIsInput;
    logic bitRateOut;
    logic reserved;
  } spc_clk_cfg_t;
endpackage : spc_pkg

//--- spc_link_model.sv
// partner model: transmit shifter timing and remote station receive events
module spc_link_model
  import spc_pkg::*;
#(
  parameter int LOAD_DLY = 3,
  parameter int MSB_DLY = 8
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // from the block
  input wire logic txStartStb,
  // bench command
  input wire spc_rx_evt_t rxCmd,
  // to the block
  output logic txLoadEvt,
  output logic txMsbEvt,
  output spc_rx_evt_t rxEvt
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ---------------------------------------------------------------
  // transmit: one character per start, nothing queued behind it
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    txLoadEvt <= 1'b0;
    txMsbEvt <= 1'b0;
    if (sys_rst) begin
      cnt <= 0;
    end else if (txStartStb) begin
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= (cnt == LOAD_DLY + MSB_DLY) ? 0 : cnt + 1;
      txLoadEvt <= (cnt == LOAD_DLY);
      txMsbEvt <= (cnt == LOAD_DLY + MSB_DLY);
    end
  end
  // ---------------------------------------------------------------
  // receive: fields toggle outside the pulse so stale data never looks valid
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxEvt <= '0;
    end else if (rxCmd.done) begin
      rxEvt <= rxCmd;
    end else begin
      rxEvt <= {1'b0, ~rxEvt[10:0]};
    end
  end
endmodule : spc_link_model

//--- test_serial_port_control_register.sv
// testbench: register access, transmit, receive, address wait and clock select
module test_serial_port_control_register
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, sys_rst = 1, standbyReq = 0, psel = 0, penable = 0, pwrite = 0;
  logic syncSelect = 0, addrModeEn = 0, pready, pslverr, err, txLoadEvt, txMsbEvt, txStartStb;
  logic txPinSel, rxPinSel, txEmptyIrq, rxFullIrq, rxErrorIrq, txDoneIrq;
  logic [7:0] paddr = '0, txDataOut;
  logic [31:0] pwdata = '0, prdata, rd;
  spc_rx_evt_t rxEvt, rxCmd = '0;
  spc_clk_cfg_t clkCfg;
  int n_fail = 0, check_count = 0;
  int startCount = 0;

  spc_serial_ctrl i_dut (.ref_clk, .sys_rst, .standbyReq, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .syncSelect, .addrModeEn, .txLoadEvt, .txMsbEvt, .rxEvt, .txDataOut,
    .txStartStb, .txPinSel, .rxPinSel, .clkCfg, .txEmptyIrq, .rxFullIrq, .rxErrorIrq, .txDoneIrq);
  spc_link_model i_link (.ref_clk, .sys_rst, .txStartStb, .rxCmd, .txLoadEvt, .txMsbEvt, .rxEvt);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // start strobes are single-cycle pulses, so they are counted rather than sampled
  always @(posedge ref_clk) begin
    if (txStartStb === 1'b1) begin
      startCount <= startCount + 1;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // request held until pready is seen high with psel and penable
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    tick(3);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & mask, exp, what);
  endtask : rdc

  task automatic rxc(input logic adr, input logic fe, input logic pe, input logic [7:0] dat);
    @(posedge ref_clk);
    rxCmd <= {1'b1, adr, fe, pe, dat};
    @(posedge ref_clk);
    rxCmd <= '0;
    tick(4);
  endtask : rxc
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    tick(2);
    sys_rst <= 1'b0;
    rdc(SPC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl reset");
    rdc(SPC_FLAGS_OFS, 32'hFFFF_FFFF, 32'h0000_0084, "flags reset");
    wr(SPC_CTRL_OFS, 32'hFFFF_FF5A);
    rdc(SPC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_005A, "ctrl rw");
    wr(SPC_CTRL_OFS, 32'h0000_00A5);
    rdc(SPC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_00A5, "ctrl rw");
    standbyReq <= 1'b1;
    tick(2);
    standbyReq <= 1'b0;
    rdc(SPC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl standby");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1, "unmapped error");
    // transmit with empty and done requests; format already set while off
    wr(SPC_CTRL_OFS, 32'h0000_00A4);
    chk(txPinSel, 1'b1, "tx pin");
    chk(txEmptyIrq, 1'b1, "tx empty irq");
    apb(1'b1, SPC_TXDATA_OFS, 32'h0000_003C);
    tick(2);
    chk(txEmptyIrq, 1'b0, "tx empty drop");
    chk(txDoneIrq, 1'b0, "tx done drop");
    chk(txDataOut, 8'h3C, "tx data");
    for (int k = 0; k < 40 && txEmptyIrq !== 1'b1; k++) @(posedge ref_clk);
    chk(txEmptyIrq, 1'b1, "tx empty after load");
    for (int k = 0; k < 40 && txDoneIrq !== 1'b1; k++) @(posedge ref_clk);
    chk(txDoneIrq, 1'b1, "tx done");
    wr(SPC_CTRL_OFS, 32'h0000_0024);
    chk(txEmptyIrq, 1'b0, "tx empty disabled");
    wr(SPC_CTRL_OFS, 32'h0000_0020);
    chk(txDoneIrq, 1'b0, "tx done disabled");
    wr(SPC_CTRL_OFS, 32'h0000_0000);
    wr(SPC_TXDATA_OFS, 32'h0000_0055);
    chk(txPinSel, 1'b0, "tx pin port");
    chk(startCount, 32'h0000_0001, "tx start count");
    rdc(SPC_FLAGS_OFS, 32'h0000_0080, 32'h0000_0080, "tx empty fixed");
    // receive: normal, framing, parity, overrun
    wr(SPC_CTRL_OFS, 32'h0000_0050);
    chk(rxPinSel, 1'b1, "rx pin");
    rxc(1'b0, 1'b0, 1'b0, 8'h5A);
    chk(rxFullIrq, 1'b1, "rx full irq");
    rdc(SPC_RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_005A, "rx data");
    tick(3);
    chk(rxFullIrq, 1'b0, "rx full drop");
    rxc(1'b0, 1'b1, 1'b0, 8'h00);
    chk(rxErrorIrq, 1'b1, "framing irq");
    wr(SPC_FLAGS_OFS, 32'h0000_00E8);
    chk(rxErrorIrq, 1'b0, "framing drop");
    rxc(1'b0, 1'b0, 1'b1, 8'h00);
    chk(rxErrorIrq, 1'b1, "parity irq");
    wr(SPC_CTRL_OFS, 32'h0000_0010);
    chk(rxErrorIrq, 1'b0, "rx enable drop");
    wr(SPC_FLAGS_OFS, 32'h0000_00F0);
    wr(SPC_CTRL_OFS, 32'h0000_0050);
    rxc(1'b0, 1'b0, 1'b0, 8'h11);
    rxc(1'b0, 1'b0, 1'b0, 8'h22);
    rdc(SPC_FLAGS_OFS, 32'h0000_0078, 32'h0000_0060, "overrun");
    chk(rxErrorIrq, 1'b1, "overrun irq");
    wr(SPC_CTRL_OFS, 32'h0000_0040);
    chk(rxPinSel, 1'b0, "rx pin port");
    rxc(1'b0, 1'b0, 1'b0, 8'h33);
    rdc(SPC_FLAGS_OFS, 32'h0000_0078, 32'h0000_0060, "flags kept");
    rdc(SPC_RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_0011, "rx data kept");
    wr(SPC_FLAGS_OFS, 32'h0000_00D8);
    // address wait: skipped data character, then address character
    addrModeEn <= 1'b1;
    wr(SPC_CTRL_OFS, 32'h0000_0058);
    rxc(1'b0, 1'b1, 1'b0, 8'h44);
    rdc(SPC_FLAGS_OFS, 32'h0000_007A, 32'h0000_0000, "wait skips");
    chk({rxFullIrq, rxErrorIrq}, 2'b00, "wait irqs");
    rxc(1'b1, 1'b0, 1'b0, 8'h66);
    rdc(SPC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0050, "wait cleared");
    rdc(SPC_FLAGS_OFS, 32'h0000_007A, 32'h0000_0042, "address char");
    rdc(SPC_RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_0066, "address data");
    // wait bit has no effect in synchronous mode
    syncSelect <= 1'b1;
    wr(SPC_CTRL_OFS, 32'h0000_0058);
    rxc(1'b0, 1'b0, 1'b0, 8'h77);
    rdc(SPC_RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_0077, "sync ignores wait");
    addrModeEn <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      syncSelect <= i[2];
      wr(SPC_CTRL_OFS, {24'h00_0000, 6'h00, i[1:0]});
      chk(clkCfg.clkIsInput, i[1:0] == 2'b10, "clock input");
      chk(clkCfg.clkOutEn, (i[1:0] == 2'b00 && i[2]) || (i[1:0] == 2'b01 && !i[2]), "clock output");
      chk(clkCfg.bitRateOut, i[1:0] == 2'b01 && !i[2], "bit rate output");
      chk(clkCfg.reserved, i[1:0] == 2'b11 || (i[2] && i[1:0] == 2'b01), "clock reserved");
    end
    end_of_test();
  end

  initial begin
    tick(20000);
    n_fail++;
    end_of_test();
  end
endmodule : test_serial_port_control_register
